// ### verilog/pbi_bridge.sv
// Peripheral bus interface: Avalon slave bridging the control processor to controller communities.
`timescale 1ns/1ps
// What this block does
// [RL1] Serve four communities of four controllers, signals replicated per community index.
// [RL2] Bridge 16-bit processor words to 8-bit controller bytes both ways.
// [RL3] A selection register picks the one controller served and steers address, data.
// [RL4] Each controller has error, interrupt, service, acknowledge and own select lines.
// [RL5] Community shares 8 data plus parity, 16-bit address, 8-bit control bus.
// [RL6] Talk to a controller by DMA-style writes into its shared mailbox memory.
// [RL7] Only the selected controller reacts; others ignore the community lines.
// [RL8] Address counter loads target address, routed only to the selected community.
// [RL9] Outgoing write data is first placed in the 16-bit holding register.
// [RL10] One 16-bit load of the holding register goes out as two bytes.
// [RL11] Reads assemble two received bytes into the holding register for one word read.
// [RL12] Control bits step the address counter and choose high or low byte.
// [RL13] Eight control bits drive the selected controller; four responses return per controller.
// [RL14] Control bus carries command interrupt, clear, complete, request, write, isolation lines.
// [RL15] Data lines are tri-state, noninverted, with one parity bit over eight bits.
// [RL16] Each controller drives its own acknowledge, error, interrupt and service lines.
// [RL17] Select and address lines are driven by this block only.
// [RL18] Gather the interrupts of in-service, non-isolated controllers into one summary toward the central unit.
// [RL19] Isolate a faulty controller with the set and release isolation lines; only release reaches it, as a set isolates before its drive.
// [RL20] Place controllers in or out of service and report their status.
// [RL21] At most one select line is asserted per community.
// [RL22] Check parity on every received byte and flag mismatches as errors.
module pbi_bridge
  import pbi_pkg::*;
#(
  parameter int COMMUNITIES = 4,
  parameter int PER_COMM = 4
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Community buses.
  output pbi_comm_out_type comm_out [COMMUNITIES],
  input wire pbi_comm_in_type comm_in [COMMUNITIES],
  // Collective interrupt summary to the central unit.
  output logic summary_irq_out
);

  localparam int NPC = COMMUNITIES * PER_COMM;

  // ----------------------------------------------------------------
  // Sequencer for byte transfers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_DRIVE, ST_NEXT} pbi_state_type;

  pbi_state_type state_reg;
  pbi_state_type state_next;
  logic [3:0] select_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] inserv_reg;
  logic [15:0] isol_reg;
  logic [15:0] perr_reg;
  logic [3:0] cnt_reg;
  logic byte_hi_reg;
  logic bytes_left_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [NPC-1:0] irq_vec;
  logic [NPC-1:0] err_vec;
  logic [NPC-1:0] srv_vec;
  logic [NPC-1:0] ack_vec;

  // Odd parity over the data byte; even-count of ones makes the parity bit one.
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction

  // Bus decode: writes are taken in one cycle, reads answer one cycle later.
  wire [1:0] sel_comm = select_reg[3:2];
  wire [1:0] sel_pc = select_reg[1:0];
  wire wr_sel = avs_write_in && (avs_address_in == PBI_OFS_SELECT);
  wire wr_addr = avs_write_in && (avs_address_in == PBI_OFS_ADDR);
  wire wr_data = avs_write_in && (avs_address_in == PBI_OFS_DATA);
  wire wr_ctrl = avs_write_in && (avs_address_in == PBI_OFS_CTRL);
  wire wr_insv = avs_write_in && (avs_address_in == PBI_OFS_INSERV);
  wire wr_isol = avs_write_in && (avs_address_in == PBI_OFS_ISOL);
  wire busy = (state_reg != ST_IDLE);
  wire go = wr_ctrl && avs_writedata_in[PBI_CB_GO] && !busy;
  wire rd_stall = avs_read_in && !ack_reg;
  wire [15:0] sel_onehot = 16'h0001 << select_reg;
  wire sel_ok = inserv_reg[select_reg] && !isol_reg[select_reg];
  wire in_par = comm_in[sel_comm].parity;
  wire [7:0] in_byte = comm_in[sel_comm].data;
  wire par_bad = (odd_par(in_byte) != in_par);
  wire step_done = (cnt_reg == 4'h1);

  // Response vectors flattened across communities; one per controller.  see [RL4] see [RL16]
  genvar gc;
  generate
    for (gc = 0; gc < COMMUNITIES; gc++) begin : g_resp
      assign irq_vec[gc*PER_COMM +: PER_COMM] = comm_in[gc].irq;
      assign err_vec[gc*PER_COMM +: PER_COMM] = comm_in[gc].err;
      assign srv_vec[gc*PER_COMM +: PER_COMM] = comm_in[gc].srv;
      assign ack_vec[gc*PER_COMM +: PER_COMM] = comm_in[gc].ack;
    end
  endgenerate

  // Interrupts of in-service, non-isolated controllers merge into one summary.
  wire [NPC-1:0] live_irq = irq_vec & inserv_reg[NPC-1:0] & ~isol_reg[NPC-1:0];  // see [RL18]

  // Read mux; unmapped addresses read zero.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (avs_address_in)
      PBI_OFS_SELECT: rmux = {28'h0, select_reg};
      PBI_OFS_ADDR: rmux = {16'h0, addr_reg};
      PBI_OFS_DATA: rmux = {16'h0, data_reg};  // see [RL11]
      PBI_OFS_CTRL: rmux = {16'h0, ctrl_reg};
      PBI_OFS_STATUS: rmux = {15'h0, busy, perr_reg};  // see [RL22]
      PBI_OFS_INTSUM: rmux = {16'h0, live_irq};
      PBI_OFS_ERRSUM: rmux = {16'h0, err_vec};  // see [RL20]
      PBI_OFS_SRVSUM: rmux = {16'h0, srv_vec};
      PBI_OFS_ACKSUM: rmux = {16'h0, ack_vec};
      PBI_OFS_INSERV: rmux = {16'h0, inserv_reg};
      PBI_OFS_ISOL: rmux = {16'h0, isol_reg};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // Next state: a go strobe starts one or two byte steps of fixed length.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (go) state_next = ST_DRIVE;
      ST_DRIVE: if (step_done) state_next = bytes_left_reg ? ST_NEXT : ST_IDLE;
      ST_NEXT: state_next = ST_DRIVE;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave answer
  // ----------------------------------------------------------------
  // Readdata is registered, so a read waits exactly one cycle.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= rd_stall;
      rdata_reg <= rmux;
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign avs_waitrequest_out = rd_stall;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      select_reg <= PBI_RST_SELECT;
      ctrl_reg <= PBI_RST_CTRL;
      inserv_reg <= PBI_RST_INSERV;
      isol_reg <= 16'h0000;
    end else begin
      if (wr_sel && !busy) select_reg <= avs_writedata_in[3:0];  // see [RL3]
      if (wr_ctrl && !busy) ctrl_reg <= {avs_writedata_in[15:9], 1'b0, avs_writedata_in[7:0]};
      if (wr_insv) inserv_reg <= avs_writedata_in[15:0];  // see [RL20]
      // Isolation state follows the set and release bits of a go; the set line is never driven, as isolation masks it at once.
      if (wr_isol) begin
        isol_reg <= avs_writedata_in[15:0];
      end else if (go && avs_writedata_in[PBI_CB_ISO_SET]) begin
        isol_reg <= isol_reg | sel_onehot;  // see [RL19]
      end else if (go && avs_writedata_in[PBI_CB_ISO_REL]) begin
        isol_reg <= isol_reg & ~sel_onehot;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine: address counter, holding register, byte steps
  // ----------------------------------------------------------------
  // When INC or DEC is set, the counter steps after each byte so the word lands in consecutive mailbox bytes.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      addr_reg <= PBI_RST_ADDR;
      data_reg <= PBI_RST_DATA;
      perr_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      byte_hi_reg <= 1'b0;
      bytes_left_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr_addr && !busy) addr_reg <= avs_writedata_in[15:0];  // see [RL8]
      if (wr_data && !busy) data_reg <= avs_writedata_in[15:0];  // see [RL9] see [RL10]
      if (go) begin
        byte_hi_reg <= avs_writedata_in[PBI_CB_HIGH];  // see [RL12]
        bytes_left_reg <= avs_writedata_in[PBI_CB_WORD];
        cnt_reg <= 4'(PBI_STROBE_CYC);
      end else if (state_reg == ST_NEXT) begin
        byte_hi_reg <= ~byte_hi_reg;
        bytes_left_reg <= 1'b0;
        cnt_reg <= 4'(PBI_STROBE_CYC);
      end else if (state_reg == ST_DRIVE) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      if (state_reg == ST_DRIVE && step_done) begin
        // Read: capture the received byte into the chosen half.  see [RL11] see [RL2]
        if (!ctrl_reg[PBI_CB_XFER_WR]) begin
          if (byte_hi_reg) data_reg[15:8] <= in_byte;
          else data_reg[7:0] <= in_byte;
          // Sticky parity error; the set wins over a same-cycle clear.  see [RL22]
          if (par_bad) perr_reg <= perr_reg | sel_onehot;
        end
        if (ctrl_reg[PBI_CB_INC]) addr_reg <= addr_reg + 16'h0001;  // see [RL12]
        else if (ctrl_reg[PBI_CB_DEC]) addr_reg <= addr_reg - 16'h0001;
      end
      // Writing ones to the status register clears those parity flags.
      if (avs_write_in && avs_address_in == PBI_OFS_STATUS &&
          !(state_reg == ST_DRIVE && step_done && par_bad && !ctrl_reg[PBI_CB_XFER_WR])) begin
        perr_reg <= perr_reg & ~avs_writedata_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Community line drivers
  // ----------------------------------------------------------------
  // Only the selected community sees address, control and data enable; the data byte goes to all.  see [RL1] see [RL7]
  logic summary_reg;
  pbi_comm_out_type out_reg [COMMUNITIES];
  wire [7:0] out_byte = byte_hi_reg ? data_reg[15:8] : data_reg[7:0];
  wire driving = (state_reg == ST_DRIVE);

  generate
    for (gc = 0; gc < COMMUNITIES; gc++) begin : g_drv
      wire hit = (sel_comm == 2'(gc)) && driving && sel_ok;
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          out_reg[gc] <= '0;
        end else begin
          out_reg[gc].addr <= hit ? addr_reg : 16'h0000;  // see [RL8] see [RL17] see [RL5]
          out_reg[gc].data <= out_byte;  // see [RL15]
          out_reg[gc].parity <= odd_par(out_byte);
          out_reg[gc].data_oe <= hit && ctrl_reg[PBI_CB_XFER_WR];  // see [RL6]
          out_reg[gc].select <= hit ? 4'(1 << sel_pc) : 4'h0;  // see [RL21]
          out_reg[gc].ctrl <= hit ? {1'b0, ctrl_reg[6:0]} : 8'h00;  // see [RL13] see [RL14]
        end
      end
      assign comm_out[gc] = out_reg[gc];
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) summary_reg <= 1'b0;
    else summary_reg <= |live_irq;  // see [RL18]
  end

  assign summary_irq_out = summary_reg;

endmodule

// ### verilog/pbi_pkg.sv
// Package for the peripheral bus interface: register map, field layout, bus structs.
package pbi_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the Avalon word bus)
  // ----------------------------------------------------------------
  localparam logic [5:0] PBI_OFS_SELECT = 6'h00;
  localparam logic [5:0] PBI_OFS_ADDR = 6'h04;
  localparam logic [5:0] PBI_OFS_DATA = 6'h08;
  localparam logic [5:0] PBI_OFS_CTRL = 6'h0C;
  localparam logic [5:0] PBI_OFS_STATUS = 6'h10;
  localparam logic [5:0] PBI_OFS_INTSUM = 6'h14;
  localparam logic [5:0] PBI_OFS_ERRSUM = 6'h18;
  localparam logic [5:0] PBI_OFS_SRVSUM = 6'h1C;
  localparam logic [5:0] PBI_OFS_ACKSUM = 6'h20;
  localparam logic [5:0] PBI_OFS_INSERV = 6'h24;
  localparam logic [5:0] PBI_OFS_ISOL = 6'h28;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int PBI_CB_CMD_INT = 0;
  localparam int PBI_CB_CLEAR = 1;
  localparam int PBI_CB_XFER_DONE = 2;
  localparam int PBI_CB_XFER_REQ = 3;
  localparam int PBI_CB_XFER_WR = 4;
  localparam int PBI_CB_ISO_REL = 5;
  localparam int PBI_CB_ISO_SET = 6;
  localparam int PBI_CB_SPARE = 7;
  localparam int PBI_CB_GO = 8;
  localparam int PBI_CB_INC = 9;
  localparam int PBI_CB_DEC = 10;
  localparam int PBI_CB_HIGH = 11;
  localparam int PBI_CB_WORD = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PBI_RST_ADDR = 16'h0000;
  localparam logic [15:0] PBI_RST_DATA = 16'h0000;
  localparam logic [15:0] PBI_RST_CTRL = 16'h0000;
  localparam logic [3:0] PBI_RST_SELECT = 4'h0;
  localparam logic [15:0] PBI_RST_INSERV = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: bytes are held on the shared lines this long
  // ----------------------------------------------------------------
  localparam int PBI_STROBE_NS = 16;
  localparam int PBI_CLK_NS = 4;
  localparam int PBI_STROBE_CYC = (PBI_STROBE_NS + PBI_CLK_NS - 1) / PBI_CLK_NS;

  // Per-community signals towards the controllers.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic parity;
    logic data_oe;
    logic [3:0] select;
    logic [7:0] ctrl;
  } pbi_comm_out_type;

  // Per-community responses from the controllers.
  typedef struct packed {
    logic [7:0] data;
    logic parity;
    logic [3:0] ack;
    logic [3:0] err;
    logic [3:0] irq;
    logic [3:0] srv;
  } pbi_comm_in_type;

endpackage

// ### bench/pbi_bridge_chk.sv
// Checker of the peripheral bus interface port behaviour.
`timescale 1ns/1ps
module pbi_bridge_chk
  import pbi_pkg::*;
#(
  parameter int COMMUNITIES = 4,
  parameter int PER_COMM = 4
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Community buses.
  input wire pbi_comm_out_type comm_out [COMMUNITIES],
  input wire pbi_comm_in_type comm_in [COMMUNITIES],
  // Summary interrupt.
  input wire logic summary_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // With no interrupt anywhere the summary must fall quiet.
  logic any_irq;
  always_comb begin
    any_irq = 1'b0;
    for (int c = 0; c < COMMUNITIES; c++)
      any_irq = any_irq | (|comm_in[c].irq);
  end
  rd_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (avs_write_in |-> !avs_waitrequest_out)
    else $error("write was stalled");
  unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in > 6'h28 |->
    avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  irq_quiet_a: assert property (!any_irq |=> !summary_irq_out)
    else $error("summary interrupt without cause");
  // Per community line rules; an unselected community must not see a request.
  for (genvar c = 0; c < COMMUNITIES; c++) begin : g_comm
    sel_onehot_a: assert property ($onehot0(comm_out[c].select))
      else $error("more than one select");
    oe_write_a: assert property (comm_out[c].data_oe |-> comm_out[c].select != 4'h0 &&
      comm_out[c].ctrl[PBI_CB_XFER_WR]) else $error("data driven outside a write");
    par_odd_a: assert property (comm_out[c].data_oe |-> comm_out[c].parity == ~^comm_out[c].data)
      else $error("bad outgoing parity");
    spare_zero_a: assert property (comm_out[c].ctrl[PBI_CB_SPARE] == 1'b0)
      else $error("spare control bit set");
    req_sel_a: assert property (comm_out[c].select == 4'h0 |-> !comm_out[c].ctrl[PBI_CB_XFER_REQ])
      else $error("request to unselected community");
  end
endmodule
bind pbi_bridge pbi_bridge_chk #(.COMMUNITIES(COMMUNITIES), .PER_COMM(PER_COMM)) u_pbi_bridge_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .comm_out(comm_out), .comm_in(comm_in),
  .summary_irq_out(summary_irq_out));

// ### bench/pbi_ctl_model.sv
// Model of the peripheral controllers on all communities.
`timescale 1ns/1ps
module pbi_ctl_model
  import pbi_pkg::*;
(
  // Clock.
  input wire logic clk_sys_in,
  // Test controls.
  input wire logic [15:0] irq_lv_in,
  input wire logic bad_par_in,
  // Community buses.
  input wire pbi_comm_out_type comm_out_in [4],
  output pbi_comm_in_type comm_in_out [4]
);
  logic [7:0] churn_reg = 8'h00;
  // Released lines churn every cycle so a stale value is never mistaken for data.
  always_ff @(posedge clk_sys_in) begin
    churn_reg <= churn_reg + 8'h5B;
  end
  // Only the selected controller answers a read; byte is address low byte XOR 3C.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      pbi_comm_out_type o;
      o = comm_out_in[c];
      if (|o.select && o.ctrl[PBI_CB_XFER_REQ] && !o.ctrl[PBI_CB_XFER_WR] && !o.data_oe) begin
        comm_in_out[c].data = o.addr[7:0] ^ 8'h3C;
        comm_in_out[c].parity = ~^(o.addr[7:0] ^ 8'h3C) ^ bad_par_in;
      end else begin
        comm_in_out[c].data = churn_reg;
        comm_in_out[c].parity = churn_reg[0];
      end
      comm_in_out[c].ack = (o.ctrl != 8'h00) ? o.select : 4'h0;
      comm_in_out[c].irq = irq_lv_in[c*4 +: 4];
      comm_in_out[c].err = 4'h0;
      comm_in_out[c].srv = irq_lv_in[c*4 +: 4];
    end
  end
endmodule

// ### bench/tb_top.sv
// Self-checking testbench of the peripheral bus interface.
`timescale 1ns/1ps
module tb_top;
  import pbi_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic summary_irq_out;
  logic [15:0] irq_lv = 16'h0;
  logic bad_par = 1'b0;
  pbi_comm_out_type comm_out [4];
  pbi_comm_in_type comm_in [4];
  int n_errors = 0;
  int cmp_count = 0;
  logic [23:0] seen [$];
  int stray = 0;
  pbi_bridge #(.COMMUNITIES(4), .PER_COMM(4)) u_pbi_bridge (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .comm_out(comm_out), .comm_in(comm_in),
    .summary_irq_out(summary_irq_out));
  pbi_ctl_model u_pbi_ctl_model (.clk_sys_in(clk_sys_in), .irq_lv_in(irq_lv), .bad_par_in(bad_par),
    .comm_out_in(comm_out), .comm_in_out(comm_in));
  // Clock at 250 MHz.
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  // Log each new outgoing byte on community 1; community 0 must stay unselected.
  always @(posedge clk_sys_in) begin
    if (comm_out[1].data_oe === 1'b1 && (seen.size() == 0 || seen[$][23:8] !== comm_out[1].addr))
      seen.push_back({comm_out[1].addr, comm_out[1].data});
    if (comm_out[0].select !== 4'h0)
      stray++;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Avalon transfer: request held until waitrequest is sampled low.
  task automatic bus(input logic [5:0] a, input logic w, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0, wd};
    avs_write_in <= w;
    avs_read_in <= ~w;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n == 100)
      n_errors++;
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 16'h0, r);
    chk(name, exp, r);
  endtask
  // Poll until the transfer engine is idle, bounded.
  task automatic wait_idle();
    logic [31:0] r;
    for (int i = 0; i < 50; i++) begin
      bus(PBI_OFS_STATUS, 1'b0, 16'h0, r);
      if (r[16] === 1'b0)
        break;
    end
    chk("idle", 32'h0, {31'h0, r[16]});
  endtask
  task automatic t_reset();
    rdc("select", PBI_OFS_SELECT, 32'h0);
    rdc("addr", PBI_OFS_ADDR, 32'h0);
    rdc("data", PBI_OFS_DATA, 32'h0);
    rdc("ctrl", PBI_OFS_CTRL, 32'h0);
    rdc("unmapped", 6'h3C, 32'h0);
  endtask
  // Word write to community 1 controller 1: low byte first, counter steps.
  task automatic t_write();
    wr(PBI_OFS_INSERV, 16'hFFFF);
    rdc("inserv", PBI_OFS_INSERV, 32'hFFFF);
    wr(PBI_OFS_SELECT, 16'h0005);
    wr(PBI_OFS_ADDR, 16'h1230);
    wr(PBI_OFS_DATA, 16'hBEEF);
    wr(PBI_OFS_CTRL, 16'h1318); // Word, increment, go, write, request.
    wait_idle();
    chk("bytes", 32'd2, seen.size());
    chk("byte0", 32'h1230EF, seen[0]);
    chk("byte1", 32'h1231BE, seen[1]);
    chk("stray", 32'd0, stray);
    rdc("addr_step", PBI_OFS_ADDR, 32'h1232);
  endtask
  // Word read from community 2 controller 2, then a bad parity byte.
  task automatic t_read();
    wr(PBI_OFS_SELECT, 16'h000A);
    wr(PBI_OFS_ADDR, 16'h0040);
    wr(PBI_OFS_CTRL, 16'h1308); // Word, increment, go, request.
    wait_idle();
    rdc("rd_word", PBI_OFS_DATA, 32'h7D7C);
    rdc("par_ok", PBI_OFS_STATUS, 32'h0);
    bad_par <= 1'b1;
    wr(PBI_OFS_CTRL, 16'h0108);
    wait_idle();
    bad_par <= 1'b0;
    rdc("par_bad", PBI_OFS_STATUS, 32'h0400);
    wr(PBI_OFS_STATUS, 16'h0400);
    rdc("par_clr", PBI_OFS_STATUS, 32'h0);
  endtask
  // Interrupt summary, isolation and out of service.
  task automatic t_irq();
    irq_lv <= 16'h1000;
    rdc("intsum", PBI_OFS_INTSUM, 32'h1000);
    rdc("srvsum", PBI_OFS_SRVSUM, 32'h1000);
    rdc("errsum", PBI_OFS_ERRSUM, 32'h0);
    rdc("acksum", PBI_OFS_ACKSUM, 32'h0);
    chk("sum_on", 32'h1, summary_irq_out);
    wr(PBI_OFS_ISOL, 16'h1000);
    rdc("isol", PBI_OFS_ISOL, 32'h1000);
    chk("sum_iso", 32'h0, summary_irq_out);
    wr(PBI_OFS_ISOL, 16'h0000);
    wr(PBI_OFS_INSERV, 16'h0FFF);
    rdc("inserv2", PBI_OFS_INSERV, 32'h0FFF);
    chk("sum_oos", 32'h0, summary_irq_out);
    irq_lv <= 16'h0;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    finish_test();
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_irq();
    finish_test();
  end
endmodule
